// ### core/adt_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ADT_REGS_SVH
`define ADT_REGS_SVH

`define ADT_ADDR_W 4
`define ADT_OFF_TIMING 4'h0
`define ADT_OFF_MUX 4'h4
`define ADT_OFF_CTRL 4'h8
`define ADT_OFF_STATUS 4'hc

`define ADT_TIM_SRC_BIT 15
`define ADT_TIM_AST_HI 12
`define ADT_TIM_AST_LO 8
`define ADT_TIM_DIV_HI 7
`define ADT_TIM_DIV_LO 0

`define ADT_MUX_NB_BIT 31
`define ADT_MUX_SB_HI 27
`define ADT_MUX_SB_LO 24
`define ADT_MUX_NA_BIT 23
`define ADT_MUX_SA_HI 19
`define ADT_MUX_SA_LO 16

`define ADT_CTRL_ALT_BIT 0
`define ADT_CTRL_START_BIT 1
`define ADT_CTRL_END_BIT 2
`define ADT_CTRL_TRIG_HI 7
`define ADT_CTRL_TRIG_LO 5

`define ADT_STAT_DONE_BIT 3

`define ADT_TRIG_SOFTWARE 3'h0
`define ADT_TRIG_EXT_PIN 3'h1
`define ADT_TRIG_TIMER 3'h2
`define ADT_TRIG_CHARGE 3'h3
`define ADT_TRIG_AUTO 3'h7

`define ADT_CODE_OPEN 4'hf
`define ADT_CODE_INTREF 4'he
`define ADT_CODE_TEMP 4'hd

`define ADT_RESET_WORD 32'h0000_0000
`define ADT_CONV_TICKS 4'hc
`define ADT_RESP_OKAY 2'h0
`define ADT_RESP_SLVERR 2'h2

`endif

// ### core/adt_pkg.sv
// Types shared by the converter timing and input select logic
package adt_pkg;

  typedef enum logic [1:0] {
    ADT_IDLE = 2'b00,
    ADT_SAMPLE = 2'b01,
    ADT_CONVERT = 2'b10
  } adt_state_t;

  typedef struct packed {
    logic pos_open;
    logic pos_internal_ref;
    logic pos_temp_sensor;
    logic pos_analog;
    logic [3:0] pos_analog_index;
    logic neg_analog_one;
  } adt_mux_sel_t;

  typedef struct packed {
    logic negative_select;
    logic [3:0] positive_select;
  } adt_mux_setting_t;

endpackage : adt_pkg

// ### core/adt_mux_decode.sv
// Decoder of one sample multiplexer setting into input selections
`include "adt_regs.svh"
module adt_mux_decode
  import adt_pkg::*;
(
  // Setting from register
  input wire adt_mux_setting_t setting,
  // Decoded selection
  output adt_mux_sel_t sel
);

  wire is_open = setting.positive_select == `ADT_CODE_OPEN;
  wire is_intref = setting.positive_select == `ADT_CODE_INTREF;
  wire is_temp = setting.positive_select == `ADT_CODE_TEMP;

  // Codes below the special ones pick analog input N, 12 down to 0
  assign sel.pos_open = is_open;
  assign sel.pos_internal_ref = is_intref;
  assign sel.pos_temp_sensor = is_temp;
  assign sel.pos_analog = !(is_open || is_intref || is_temp);
  assign sel.pos_analog_index = setting.positive_select;
  // Negative input: analog input one or low reference
  assign sel.neg_analog_one = setting.negative_select;

endmodule : adt_mux_decode

// ### core/adt_clk_div.sv
// Conversion clock generator from bus clock divider or fast RC oscillator
`include "adt_regs.svh"
module adt_clk_div
  import adt_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration
  input wire logic source_select,
  input wire logic [7:0] divider,
  // Synchronised oscillator level
  input wire logic osc_level,
  // Conversion clock
  output logic conv_clk,
  output logic conv_tick
);

  logic [7:0] half_count;
  logic osc_last;

  wire half_end = half_count == divider;
  wire osc_rise = osc_level && !osc_last;
  wire [7:0] next_half_count = half_end ? 8'h00 : half_count + 8'h01;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      half_count <= 8'h00;
      conv_clk <= 1'b0;
      conv_tick <= 1'b0;
      osc_last <= 1'b0;
    end
    else
    begin
      osc_last <= osc_level;
      if (source_select)
      begin
        // Oscillator source; divider is not looked at
        half_count <= 8'h00;
        conv_clk <= osc_level;
        conv_tick <= osc_rise;
      end
      else
      begin
        // Bus source: half period of divider+1 cycles, full 2*(divider+1)
        half_count <= next_half_count;
        if (half_end)
          conv_clk <= !conv_clk;
        conv_tick <= half_end && !conv_clk;
      end
    end
  end

endmodule : adt_clk_div

// ### core/adt_top.sv
// Converter clock timing, auto-sample sequencing and input select with AXI4-Lite registers
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`include "adt_regs.svh"
module adt_top
  import adt_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Asynchronous pins
  input wire logic fast_rc_osc_in,
  input wire logic ext_trigger_in,
  // Same-clock trigger sources
  input wire logic timer_match,
  input wire logic charge_unit_end,
  // Conversion clock and sequencing
  output logic conv_clk_out,
  output logic sampling,
  output logic conversion_start,
  output logic conversion_done,
  output logic using_setting_b,
  // Selected analog inputs
  output adt_mux_sel_t input_select
);

  // Configuration state
  logic clk_source;
  logic [4:0] auto_sample_time;
  logic [7:0] conv_clock_divider;
  adt_mux_setting_t setting_a;
  adt_mux_setting_t setting_b;
  logic alternate_sample_enable;
  logic [2:0] conversion_trigger_source;
  logic done_flag;

  // Sequencer state
  adt_state_t state;
  logic [4:0] tick_count;

  // Pin synchronisers
  logic osc_meta;
  logic osc_sync;
  logic ext_meta;
  logic ext_sync;
  logic ext_last;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_last <= 1'b0;
    end
    else
    begin
      osc_meta <= fast_rc_osc_in;
      osc_sync <= osc_meta;
      ext_meta <= ext_trigger_in;
      ext_sync <= ext_meta;
      ext_last <= ext_sync;
    end
  end

  wire ext_edge = ext_sync && !ext_last;

  // Conversion clock
  logic conv_clk;
  logic conv_tick;

  adt_clk_div u_clk_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .source_select(clk_source),
    .divider(conv_clock_divider),
    .osc_level(osc_sync),
    .conv_clk(conv_clk),
    .conv_tick(conv_tick)
  );

  // Input setting decoders
  adt_mux_sel_t sel_a;
  adt_mux_sel_t sel_b;

  adt_mux_decode u_dec_a (
    .setting(setting_a),
    .sel(sel_a)
  );

  adt_mux_decode u_dec_b (
    .setting(setting_b),
    .sel(sel_b)
  );

  // Bus handshake: both write channels taken together, one cycle after both valid
  wire wr_take = s_axi_awready && s_axi_wready;
  wire rd_take = s_axi_arready;
  wire [`ADT_ADDR_W-1:0] wr_addr = s_axi_awaddr[`ADT_ADDR_W-1:0];
  wire [`ADT_ADDR_W-1:0] rd_addr = s_axi_araddr[`ADT_ADDR_W-1:0];
  wire wr_upper_zero = s_axi_awaddr[31:`ADT_ADDR_W] == 28'h0000000;
  wire rd_upper_zero = s_axi_araddr[31:`ADT_ADDR_W] == 28'h0000000;

  wire wr_timing = wr_take && wr_upper_zero && wr_addr == `ADT_OFF_TIMING;
  wire wr_mux = wr_take && wr_upper_zero && wr_addr == `ADT_OFF_MUX;
  wire wr_ctrl = wr_take && wr_upper_zero && wr_addr == `ADT_OFF_CTRL;
  wire wr_status = wr_take && wr_upper_zero && wr_addr == `ADT_OFF_STATUS;
  wire wr_hit = wr_timing || wr_mux || wr_ctrl || wr_status;

  // Byte-lane merge
  wire [31:0] strobe_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                             {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // Read views; unimplemented bits are zero
  wire [31:0] rd_timing_word = {16'h0000, clk_source, 2'b00, auto_sample_time,
                                conv_clock_divider};
  wire [31:0] rd_mux_word = {setting_b.negative_select, 3'b000, setting_b.positive_select,
                             setting_a.negative_select, 3'b000, setting_a.positive_select,
                             16'h0000};
  wire [31:0] rd_ctrl_word = {24'h000000, conversion_trigger_source, 4'h0,
                              alternate_sample_enable};
  wire [31:0] rd_status_word = {28'h0000000, done_flag, using_setting_b,
                                state == ADT_CONVERT, state == ADT_SAMPLE};

  wire [31:0] merged_timing = (rd_timing_word & ~strobe_mask) | (s_axi_wdata & strobe_mask);
  wire [31:0] merged_mux = (rd_mux_word & ~strobe_mask) | (s_axi_wdata & strobe_mask);
  wire [31:0] merged_ctrl = (rd_ctrl_word & ~strobe_mask) | (s_axi_wdata & strobe_mask);
  wire [31:0] merged_status = (rd_status_word & ~strobe_mask) | (s_axi_wdata & strobe_mask);

  wire sw_start = wr_ctrl && merged_ctrl[`ADT_CTRL_START_BIT];
  wire sw_end = wr_ctrl && merged_ctrl[`ADT_CTRL_END_BIT];
  wire sw_done_clear = wr_status && !merged_status[`ADT_STAT_DONE_BIT];

  wire rd_is_timing = rd_upper_zero && rd_addr == `ADT_OFF_TIMING;
  wire rd_is_mux = rd_upper_zero && rd_addr == `ADT_OFF_MUX;
  wire rd_is_ctrl = rd_upper_zero && rd_addr == `ADT_OFF_CTRL;
  wire rd_is_status = rd_upper_zero && rd_addr == `ADT_OFF_STATUS;
  wire rd_hit = rd_is_timing || rd_is_mux || rd_is_ctrl || rd_is_status;
  wire [31:0] rd_word = rd_is_timing ? rd_timing_word :
                        rd_is_mux ? rd_mux_word :
                        rd_is_ctrl ? rd_ctrl_word :
                        rd_is_status ? rd_status_word : 32'h0000_0000;

  // Sample end selection by trigger source
  wire auto_mode = conversion_trigger_source == `ADT_TRIG_AUTO;
  // Auto-sample time counts only in auto mode; zero is treated as one period
  wire [4:0] sample_limit = (auto_sample_time == 5'h00) ? 5'h01 : auto_sample_time;
  wire auto_end = auto_mode && conv_tick && (tick_count + 5'h01 >= sample_limit);
  wire trig_end = (conversion_trigger_source == `ADT_TRIG_SOFTWARE && sw_end) ||
                  (conversion_trigger_source == `ADT_TRIG_EXT_PIN && ext_edge) ||
                  (conversion_trigger_source == `ADT_TRIG_TIMER && timer_match) ||
                  (conversion_trigger_source == `ADT_TRIG_CHARGE && charge_unit_end);
  wire sample_end = (state == ADT_SAMPLE) && (auto_mode ? auto_end : trig_end);
  wire conv_end = (state == ADT_CONVERT) && conv_tick &&
                  (tick_count[3:0] + 4'h1 == `ADT_CONV_TICKS);

  adt_state_t next_state;
  assign next_state = (state == ADT_IDLE && sw_start) ? ADT_SAMPLE :
                      sample_end ? ADT_CONVERT :
                      conv_end ? ADT_IDLE : state;

  // AXI channel registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADT_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `ADT_RESP_OKAY;
      s_axi_rdata <= `ADT_RESET_WORD;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wr_take)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `ADT_RESP_OKAY : `ADT_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `ADT_RESP_OKAY : `ADT_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_source <= 1'b0;
      auto_sample_time <= 5'h00;
      conv_clock_divider <= 8'h00;
      setting_a <= 5'h00;
      setting_b <= 5'h00;
      alternate_sample_enable <= 1'b0;
      conversion_trigger_source <= `ADT_TRIG_SOFTWARE;
    end
    else
    begin
      if (wr_timing)
      begin
        clk_source <= merged_timing[`ADT_TIM_SRC_BIT];
        auto_sample_time <= merged_timing[`ADT_TIM_AST_HI:`ADT_TIM_AST_LO];
        conv_clock_divider <= merged_timing[`ADT_TIM_DIV_HI:`ADT_TIM_DIV_LO];
      end
      if (wr_mux)
      begin
        setting_b <= {merged_mux[`ADT_MUX_NB_BIT], merged_mux[`ADT_MUX_SB_HI:`ADT_MUX_SB_LO]};
        setting_a <= {merged_mux[`ADT_MUX_NA_BIT], merged_mux[`ADT_MUX_SA_HI:`ADT_MUX_SA_LO]};
      end
      if (wr_ctrl)
      begin
        alternate_sample_enable <= merged_ctrl[`ADT_CTRL_ALT_BIT];
        conversion_trigger_source <= merged_ctrl[`ADT_CTRL_TRIG_HI:`ADT_CTRL_TRIG_LO];
      end
    end
  end

  // Sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ADT_IDLE;
      tick_count <= 5'h00;
      done_flag <= 1'b0;
      using_setting_b <= 1'b0;
      sampling <= 1'b0;
      conversion_start <= 1'b0;
      conversion_done <= 1'b0;
      conv_clk_out <= 1'b0;
      input_select <= '0;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
        tick_count <= 5'h00;
      else if (conv_tick && state != ADT_IDLE)
        tick_count <= tick_count + 5'h01;
      // Set at conversion end wins over a software clear; new conversion clears it
      if (conv_end)
        done_flag <= 1'b1;
      else if (sample_end || sw_done_clear)
        done_flag <= 1'b0;
      // Setting A first, then B and A in turn while alternation is on
      if (!alternate_sample_enable)
        using_setting_b <= 1'b0;
      else if (conv_end)
        using_setting_b <= !using_setting_b;
      sampling <= next_state == ADT_SAMPLE;
      conversion_start <= sample_end;
      conversion_done <= conv_end;
      conv_clk_out <= conv_clk;
      input_select <= (alternate_sample_enable && using_setting_b) ? sel_b : sel_a;
    end
  end

endmodule : adt_top

// ### tb/adt_top_sva.sv
// Port checker for the converter timing and input select block
module adt_top_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // Sequencing
  input wire logic sampling,
  input wire logic conversion_start,
  input wire logic conversion_done,
  input wire logic using_setting_b
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_ready_pair;
    s_axi_awready |-> s_axi_wready;
  endproperty
  a_ready_pair: assert property (p_ready_pair) else $error("write readies apart");
  property p_wr_answer;
    s_axi_awready |=> s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_wr_cause;
    $rose(s_axi_bvalid) |-> $past(s_axi_awready);
  endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("write answer without request");
  property p_rd_answer;
    s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_cause;
    $rose(s_axi_rvalid) |-> $past(s_axi_arready);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read answer without request");
  property p_rd_zero;
    s_axi_rvalid |-> s_axi_rdata[30:28] == 3'h0 && s_axi_rdata[22:20] == 3'h0
      && s_axi_rdata[14:13] == 2'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unused bits read nonzero");
  property p_alt_step;
    $rose(using_setting_b) |-> conversion_done || $past(conversion_done);
  endproperty
  a_alt_step: assert property (p_alt_step) else $error("setting b outside step");
  property p_start_ends;
    conversion_start |-> !sampling && $past(sampling) ##1 !conversion_start;
  endproperty
  a_start_ends: assert property (p_start_ends) else $error("start without end");
endmodule : adt_top_chk

bind adt_top adt_top_chk chk_u (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .sampling,
  .conversion_start, .conversion_done, .using_setting_b);

// ### tb/adc_timing_and_input_select_tb.sv
// Register level testbench for the converter timing and input select block
`include "adt_regs.svh"
module adc_timing_and_input_select_tb
  import adt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ra_tim = 32'(`ADT_OFF_TIMING);
  localparam logic [31:0] ra_mux = 32'(`ADT_OFF_MUX);
  localparam logic [31:0] ra_ctl = 32'(`ADT_OFF_CTRL);
  localparam logic [31:0] ra_st = 32'(`ADT_OFF_STATUS);
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [2:0] trg = 3'h0;
  logic osc = 1'b0, pc = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, cclk, samp, cstart, cdone, useb;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  adt_mux_sel_t isel;
  int fail_count = 0, samples_checked = 0, cyc = 0, lastr = 0, per = 0, slen = 0, slast = 0;
  int nst = 0;
  int tw[5] = '{32'h0, 32'h1, 32'h5, 32'h8005, 32'h80ff};
  int tp[5] = '{2, 4, 12, 8, 8};

  adt_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fast_rc_osc_in(osc), .ext_trigger_in(trg[0]), .timer_match(trg[1]),
    .charge_unit_end(trg[2]), .conv_clk_out(cclk), .sampling(samp),
    .conversion_start(cstart), .conversion_done(cdone), .using_setting_b(useb),
    .input_select(isel));

  always #5 aclk = ~aclk;

  // Conversion clock period, sampling length and a free running oscillator of 8 cycles
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    pc <= cclk;
    if (cclk && !pc)
    begin
      per <= cyc - lastr;
      lastr <= cyc;
    end
    if (!samp && slen != 0)
      slast <= slen;
    slen <= samp ? slen + 1 : 0;
    if (cstart)
      nst <= nst + 1;
    if (cyc % 4 == 0)
      osc <= ~osc;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge aclk);
    while (!awready) @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk(32'(rresp), 32'(er));
    chk(rdata, exp);
    @(posedge aclk);
  endtask : rd

  task automatic wait_done();
    do @(posedge aclk); while (!cdone);
    repeat (2) @(posedge aclk);
  endtask : wait_done

  // Walks every positive code on one setting while the other holds the inverse
  task automatic dec(input int s);
    logic [3:0] c;
    adt_mux_sel_t e;
    adt_mux_sel_t g;
    for (int i = 0; i < 16; i++)
    begin
      c = 4'(i);
      if (i == 15)
        wr(ra_ctl, 32'h60 | 32'(s), 2'h0);
      if (s != 0)
        wr(ra_mux, {c[0], 3'h0, c, ~c[0], 3'h0, ~c, 16'h0}, 2'h0);
      else
        wr(ra_mux, {~c[0], 3'h0, ~c, c[0], 3'h0, c, 16'h0}, 2'h0);
      repeat (2) @(posedge aclk);
      e = '{c == 4'hf, c == 4'he, c == 4'hd, c <= 4'hc, (c <= 4'hc) ? c : 4'h0, c[0]};
      g = isel;
      if (c > 4'hc)
        g.pos_analog_index = 4'h0;
      chk(32'(g), 32'(e));
    end
  endtask : dec

  initial
  begin
    #500000;
    fail_count++;
    close_out();
  end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ra_tim, 32'h0, 2'h0);
    rd(ra_mux, 32'h0, 2'h0);
    wr(ra_tim, 32'hffff_ffff, 2'h0);
    rd(ra_tim, 32'h0000_9fff, 2'h0);
    wr(ra_mux, 32'hffff_ffff, 2'h0);
    rd(ra_mux, 32'h8f8f_0000, 2'h0);
    wr(32'h10, 32'h1, 2'h2);
    rd(32'h10, 32'h0, 2'h2);
    wr(ra_tim, 32'h0, 2'h0);
    dec(0);
    wr(ra_ctl, 32'h1, 2'h0);
    chk(32'(useb), 32'h0);
    wr(ra_ctl, 32'h3, 2'h0);
    wr(ra_ctl, 32'h5, 2'h0);
    wait_done();
    chk(32'(useb), 32'h1);
    rd(ra_st, 32'hc, 2'h0);
    wr(ra_st, 32'h0, 2'h0);
    rd(ra_st, 32'h4, 2'h0);
    dec(1);
    wr(ra_ctl, 32'h0, 2'h0);
    repeat (2) @(posedge aclk);
    chk(32'(useb), 32'h0);
    for (int k = 0; k < 5; k++)
    begin
      wr(ra_tim, tw[k], 2'h0);
      repeat (300) @(posedge aclk);
      chk(per, tp[k]);
    end
    for (int s = 1; s < 30; s += 9)
    begin
      wr(ra_tim, 32'(s) << 8, 2'h0);
      wr(ra_ctl, 32'he2, 2'h0);
      wait_done();
      chk(32'(slast >= 2 * s - 1 && slast <= 2 * s + 2), 32'h1);
    end
    wr(ra_ctl, 32'h2, 2'h0);
    repeat (80) @(posedge aclk);
    chk(32'(samp), 32'h1);
    wr(ra_ctl, 32'h4, 2'h0);
    wait_done();
    for (int t = 1; t < 4; t++)
    begin
      wr(ra_ctl, (32'(t) << 5) | 32'h2, 2'h0);
      trg <= 3'h7 ^ (3'h1 << (t - 1));
      repeat (8) @(posedge aclk);
      chk(32'(samp), 32'h1);
      trg <= 3'h1 << (t - 1);
      wait_done();
      trg <= 3'h0;
      @(posedge aclk);
    end
    chk(nst, 32'h9);
    close_out();
  end
endmodule : adc_timing_and_input_select_tb
